/* rtl/pkt_pkg.sv */
// Constants, command codes, configuration array layout and CRC helpers
// for the packet handler. Assumes one 40 MHz system clock.
//
// Summary of operation
// - Manchester coding only with the packet handler, applied to the whole packet
// - With Manchester on, preamble is sent as all ones, same chip rate
// - Manchester polarity selects chip pair 10 or 01 for a one
// - Preamble length 0 to 255 bytes, default four bytes
// - Preamble bytes are 55h, first bit sent is zero
// - Sync word follows preamble directly, length one to four bytes
// - Default sync word is two bytes: 2d then d4
// - With CRC on, transmitter appends CRC as last packet bytes
// - Receiver checks CRC; match raises valid-packet event, data kept
// - CRC mismatch raises packet-error event instead of valid-packet
// - CRC polynomial x16+x15+x2+1, preset all ones per packet
// - Alternative 16-bit ITU-T CRC is selectable
// - Preamble sense detects a preamble within eight bit periods
// - Preamble sense duty-cycles the receiver without host help
// - Array write and transmit FIFO write share command byte 66h
// - Apply command loads the array; verify command checks it
// - Clear-to-send reads FFh only after the command has executed

package pkt_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int BIT_RATE_BPS = 100_000;
	localparam int CHIP_CYC = CLK_HZ / (2 * BIT_RATE_BPS);
	localparam logic [7:0] CHIP_LAST = 8'(CHIP_CYC - 1);
	localparam int DETECT_BITS = 8;
	localparam logic [3:0] DETECT_RUN = 4'(DETECT_BITS - 1);
	localparam logic [15:0] SNIFF_ON_CYC = 16'(4 * CHIP_CYC * DETECT_BITS);
	localparam int SNIFF_OFF_DEF = 16000;
	localparam int FIFO_DEPTH = 8;

	localparam logic [7:0] CMD_WRITE = 8'h66;
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_CTS = 8'h44;
	localparam logic [7:0] CMD_APPLY = 8'h15;
	localparam logic [7:0] CMD_VERIFY = 8'h19;

	localparam logic [7:0] PRE_BYTE = 8'h55;
	localparam logic [7:0] PRE_LEN_DEF = 8'h04;
	localparam logic [2:0] SYNC_LEN_DEF = 3'h2;
	localparam logic [31:0] SYNC_DEF = 32'h2dd40000;
	localparam logic [15:0] CRC_SEED = 16'hffff;
	localparam logic [15:0] POLY_IBM = 16'h8005;
	localparam logic [15:0] POLY_ITU = 16'h1021;

	// Configuration array: flags, preamble length, sync length, sync bytes
	localparam logic [2:0] CFG_BYTES = 3'h7;
	localparam int CFG_FLAGS = 0;
	localparam int CFG_PRE = 1;
	localparam int CFG_SLEN = 2;
	localparam int CFG_SYNC = 3;
	localparam int F_MANCH = 0;
	localparam int F_POL = 1;
	localparam int F_CRC = 2;
	localparam int F_ITU = 3;
	localparam int F_PSM = 4;
	localparam logic [7:0] FLAGS_DEF = 8'h04;

	// One bit of an MSB-first CRC; no final inversion, so a frame
	// followed by its own CRC leaves a zero remainder
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b, input logic itu);
		crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? (itu ? POLY_ITU : POLY_IBM) : 16'h0000);
	endfunction

	function automatic logic [31:0] len_mask(input logic [2:0] len);
		len_mask = ~(32'hffffffff << {len, 3'h0});
	endfunction
endpackage

/* rtl/pkt_fifo.sv */
// Synchronous FIFO for transmit payload bytes.
// Assumes DEPTH is a power of two; both sides on the system clock.
`timescale 1ns/1ps

module pkt_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready_out = cnt_q != FULL;
	assign out_valid_out = cnt_q != '0;
	assign out_data_out = mem_q[rd_q];
	assign push = in_valid_in & in_ready_out;
	assign pop = out_ready_in & out_valid_out;

	always_ff @(posedge clk_sys_in)
	begin
		if (push)
			mem_q[wr_q] <= in_data_in;
	end

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push & ~pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop & ~push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

/* rtl/radio_packet_handler.sv */
// Packet handler: host serial port, configuration array, transmit framer,
// receive deframer with preamble sense duty cycling.
// Serial pins are asynchronous; demodulated receive bits arrive on clk_sys_in.
`timescale 1ns/1ps

module radio_packet_handler #(
	parameter int SNIFF_OFF_CYC = pkt_pkg::SNIFF_OFF_DEF
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic host_select_n_in,
	input wire logic spi_clk_in,
	input wire logic host_to_device_line_in,
	output logic device_to_host_line_out,
	input wire logic tx_start_in,
	input wire logic [7:0] tx_len_in,
	output logic tx_chip_out,
	output logic tx_active_out,
	input wire logic rx_enable_in,
	input wire logic rx_bit_in,
	input wire logic rx_bit_strobe_in,
	input wire logic [7:0] rx_len_in,
	output logic rx_on_out,
	output logic preamble_detected_out,
	output logic sync_found_out,
	output logic [7:0] rx_byte_out,
	output logic rx_byte_valid_out,
	output logic packet_valid_out,
	output logic packet_error_out,
	output logic config_applied_out,
	output logic config_ok_out
);
	import pkt_pkg::*;

	typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_SYNC, TX_PAY, TX_CRC} tx_state_type;
	typedef enum logic [1:0] {RX_HUNT, RX_SYNC, RX_DATA} rx_state_type;
	localparam logic [15:0] SNIFF_OFF_LAST = 16'(SNIFF_OFF_CYC - 1);

	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	////////////////////////////////////////////////////////////////////////
	// Host serial port
	logic [2:0] sel_s_q;
	logic [2:0] sck_s_q;
	logic [1:0] mosi_s_q;
	logic sel_n;
	logic sck_rise;
	logic sck_fall;
	logic sel_rise;

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sel_s_q <= 3'h7;
			sck_s_q <= 3'h0;
			mosi_s_q <= 2'h0;
		end
		else
		begin
			sel_s_q <= {sel_s_q[1:0], host_select_n_in};
			sck_s_q <= {sck_s_q[1:0], spi_clk_in};
			mosi_s_q <= {mosi_s_q[0], host_to_device_line_in};
		end
	end

	assign sel_n = sel_s_q[1];
	assign sel_rise = sel_s_q[1] & ~sel_s_q[2];
	assign sck_rise = sck_s_q[1] & ~sck_s_q[2];
	assign sck_fall = ~sck_s_q[1] & sck_s_q[2];

	logic [2:0] bit_idx_q;
	logic [6:0] sh_q;
	logic first_q;
	logic byte_done_q;
	logic byte_is_cmd_q;
	logic [7:0] byte_q;

	// The first byte after select falls is the command
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			bit_idx_q <= 3'h0;
			sh_q <= 7'h00;
			first_q <= 1'b1;
			byte_done_q <= 1'b0;
			byte_is_cmd_q <= 1'b0;
			byte_q <= 8'h00;
		end
		else
		begin
			byte_done_q <= 1'b0;
			if (byte_done_q)
				first_q <= 1'b0;
			if (sel_n)
			begin
				bit_idx_q <= 3'h0;
				first_q <= 1'b1;
			end
			else if (sck_rise)
			begin
				sh_q <= {sh_q[5:0], mosi_s_q[1]};
				bit_idx_q <= bit_idx_q + 3'h1;
				if (bit_idx_q == 3'h7)
				begin
					byte_q <= {sh_q, mosi_s_q[1]};
					byte_done_q <= 1'b1;
					byte_is_cmd_q <= first_q;
				end
			end
		end
	end

	logic cmd_done;
	logic data_done;
	logic [7:0] cmd_q;
	logic cts_q;
	logic cts_rd_q;
	logic dout_q;

	assign cmd_done = byte_done_q & byte_is_cmd_q;
	assign data_done = byte_done_q & ~byte_is_cmd_q;

	// Commands execute when select rises; clear-to-send then reads FFh
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cmd_q <= CMD_NOP;
			cts_q <= 1'b1;
			cts_rd_q <= 1'b0;
			dout_q <= 1'b0;
		end
		else
		begin
			if (sel_rise)
				cts_q <= 1'b1;
			else if (cmd_done && byte_q != CMD_CTS)
				cts_q <= 1'b0;
			if (sel_n)
				cmd_q <= CMD_NOP;
			else if (cmd_done)
				cmd_q <= byte_q;
			if (sel_n)
				cts_rd_q <= 1'b0;
			else if (cmd_done)
				cts_rd_q <= byte_q == CMD_CTS;
			if (sel_n)
				dout_q <= 1'b0;
			else if (sck_fall)
				dout_q <= cts_rd_q & cts_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration array
	logic [7:0] cfg_mem_q [7];
	logic [2:0] cfg_ptr_q;
	logic [1:0] arr_cmds_q;
	logic nop_seen_q;
	logic cfg_loaded_q;
	logic cfg_ok_q;
	logic [7:0] flags_q;
	logic [7:0] pre_len_q;
	logic [2:0] sync_len_q;
	logic [31:0] sync_q;
	logic wr_cfg;
	logic wr_fifo;
	logic manch;
	logic pol;
	logic crc_en;
	logic itu;
	logic preamble_sense_rx_mode;

	// Same opcode: array bytes before the apply command, FIFO bytes after
	assign wr_cfg = data_done & (cmd_q == CMD_WRITE) & ~cfg_loaded_q;
	assign wr_fifo = data_done & (cmd_q == CMD_WRITE) & cfg_loaded_q;
	assign manch = flags_q[F_MANCH];
	assign pol = flags_q[F_POL];
	assign crc_en = flags_q[F_CRC];
	assign itu = flags_q[F_ITU];
	assign preamble_sense_rx_mode = flags_q[F_PSM];

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			for (int i = 0; i < 7; i++)
				cfg_mem_q[i] <= 8'h00;
			cfg_ptr_q <= 3'h0;
			arr_cmds_q <= 2'h0;
			nop_seen_q <= 1'b0;
			cfg_loaded_q <= 1'b0;
			cfg_ok_q <= 1'b0;
			flags_q <= FLAGS_DEF;
			pre_len_q <= PRE_LEN_DEF;
			sync_len_q <= SYNC_LEN_DEF;
			sync_q <= SYNC_DEF;
		end
		else
		begin
			if (cmd_done && byte_q == CMD_WRITE && !cfg_loaded_q && arr_cmds_q != 2'h2)
				arr_cmds_q <= arr_cmds_q + 2'h1;
			if (cmd_done && byte_q == CMD_NOP && arr_cmds_q == 2'h1)
				nop_seen_q <= 1'b1;
			if (wr_cfg && cfg_ptr_q != CFG_BYTES)
			begin
				cfg_mem_q[cfg_ptr_q] <= byte_q;
				cfg_ptr_q <= cfg_ptr_q + 3'h1;
			end
			if (sel_rise && cmd_q == CMD_APPLY)
			begin
				cfg_loaded_q <= 1'b1;
				flags_q <= cfg_mem_q[CFG_FLAGS];
				pre_len_q <= cfg_mem_q[CFG_PRE];
				sync_len_q <= cfg_mem_q[CFG_SLEN][2:0];
				sync_q <= {cfg_mem_q[CFG_SYNC], cfg_mem_q[CFG_SYNC+1], cfg_mem_q[CFG_SYNC+2],
					cfg_mem_q[CFG_SYNC+3]};
			end
			if (sel_rise && cmd_q == CMD_VERIFY)
				cfg_ok_q <= cfg_loaded_q && cfg_ptr_q == CFG_BYTES && arr_cmds_q == 2'h2 && nop_seen_q
					&& sync_len_q != 3'h0 && sync_len_q <= 3'h4;
		end
	end

	a_apply_cmd: assert property ($rose(cfg_loaded_q) |-> $past(sel_rise && cmd_q == CMD_APPLY))
		else $error("configuration applied without apply command");

	////////////////////////////////////////////////////////////////////////
	// Transmit framer
	logic fifo_out_valid;
	logic fifo_pop;
	logic [7:0] fifo_data;

	pkt_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) payload_fifo (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.in_valid_in(wr_fifo),
		.in_ready_out(),
		.in_data_in(byte_q),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(fifo_pop),
		.out_data_out(fifo_data)
	);

	tx_state_type tx_st_q;
	logic [7:0] tx_cnt_q;
	logic half_q;
	logic [2:0] tbit_q;
	logic [7:0] tbyte_q;
	logic [7:0] tsh_q;
	logic [15:0] tcrc_q;
	logic [7:0] tlen_q;
	logic tx_chip_q;
	logic tx_active_q;
	logic cur_bit;
	logic chip0;
	logic chip1;
	logic tick;
	logic bit_end;
	logic byte_end;
	logic stall;
	logic [15:0] crc_n;
	tx_state_type nst;
	logic [7:0] nbyte;
	logic [7:0] ncnt;
	logic need_pop;
	logic [31:0] sy;

	assign cur_bit = (tx_st_q == TX_PRE && manch) ? 1'b1 : tsh_q[7];
	assign chip0 = manch ? cur_bit ^ pol : cur_bit;
	assign chip1 = manch ? ~chip0 : cur_bit;
	assign tick = tx_cnt_q == CHIP_LAST;
	assign bit_end = tick & half_q;
	assign byte_end = bit_end & (tbit_q == 3'h7);
	assign crc_n = (tx_st_q == TX_PAY) ? crc_step(tcrc_q, tsh_q[7], itu) : tcrc_q;
	// A payload byte that is not yet in the FIFO stretches the last chip;
	// bytes that meet a full FIFO are dropped, so the host paces its writes
	assign stall = byte_end & need_pop & ~fifo_out_valid;
	assign fifo_pop = byte_end & need_pop & fifo_out_valid;

	always_comb
	begin
		nst = tx_st_q;
		nbyte = 8'h00;
		need_pop = 1'b0;
		ncnt = tbyte_q + 8'h01;
		sy = sync_q << {ncnt[1:0], 3'h0};
		unique case (tx_st_q)
			TX_IDLE:
				nst = TX_IDLE;
			TX_PRE:
				if (ncnt == pre_len_q)
				begin
					nst = TX_SYNC;
					ncnt = 8'h00;
					nbyte = sync_q[31:24];
				end
				else
					nbyte = PRE_BYTE;
			TX_SYNC:
				if (ncnt == {5'h00, sync_len_q})
				begin
					ncnt = 8'h00;
					if (tlen_q != 8'h00)
					begin
						nst = TX_PAY;
						nbyte = fifo_data;
						need_pop = 1'b1;
					end
					else if (crc_en)
					begin
						nst = TX_CRC;
						nbyte = crc_n[15:8];
					end
					else
						nst = TX_IDLE;
				end
				else
					nbyte = sy[31:24];
			TX_PAY:
				if (ncnt == tlen_q)
				begin
					ncnt = 8'h00;
					nst = crc_en ? TX_CRC : TX_IDLE;
					nbyte = crc_n[15:8];
				end
				else
				begin
					nbyte = fifo_data;
					need_pop = 1'b1;
				end
			TX_CRC:
				if (ncnt == 8'h02)
					nst = TX_IDLE;
				else
					nbyte = tcrc_q[7:0];
		endcase
	end

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			tx_st_q <= TX_IDLE;
			tx_cnt_q <= 8'h00;
			half_q <= 1'b0;
			tbit_q <= 3'h0;
			tbyte_q <= 8'h00;
			tsh_q <= 8'h00;
			tcrc_q <= CRC_SEED;
			tlen_q <= 8'h00;
		end
		else if (tx_st_q == TX_IDLE)
		begin
			tx_cnt_q <= 8'h00;
			half_q <= 1'b0;
			tbit_q <= 3'h0;
			tbyte_q <= 8'h00;
			if (tx_start_in && cfg_loaded_q)
			begin
				tx_st_q <= (pre_len_q != 8'h00) ? TX_PRE : TX_SYNC;
				tsh_q <= (pre_len_q != 8'h00) ? PRE_BYTE : sync_q[31:24];
				tcrc_q <= CRC_SEED;
				tlen_q <= tx_len_in;
			end
		end
		else if (!stall)
		begin
			tx_cnt_q <= tick ? 8'h00 : tx_cnt_q + 8'h01;
			if (tick)
				half_q <= ~half_q;
			if (bit_end)
			begin
				tbit_q <= tbit_q + 3'h1;
				tsh_q <= {tsh_q[6:0], 1'b0};
				tcrc_q <= crc_n;
				if (byte_end)
				begin
					tsh_q <= nbyte;
					tbyte_q <= ncnt;
					tx_st_q <= nst;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			tx_chip_q <= 1'b0;
			tx_active_q <= 1'b0;
		end
		else
		begin
			tx_chip_q <= (tx_st_q != TX_IDLE) && (half_q ? chip1 : chip0);
			tx_active_q <= tx_st_q != TX_IDLE;
		end
	end

	a_pre_first_zero: assert property ($rose(tx_st_q == TX_PRE) |-> tsh_q == PRE_BYTE && !tsh_q[7])
		else $error("preamble does not start with 55h");
	a_sync_after_pre: assert property ($fell(tx_st_q == TX_PRE) |-> tx_st_q == TX_SYNC)
		else $error("preamble not followed by sync word");
	a_manch_flip: assert property ((tx_st_q != TX_IDLE && manch && tick && !half_q) ##1 tx_st_q != TX_IDLE
		|=> tx_chip_q != $past(tx_chip_q))
		else $error("manchester chips of one bit are equal");
	a_pre_manch_ones: assert property (tx_st_q == TX_PRE && manch |-> cur_bit)
		else $error("manchester preamble bit is not one");
	a_crc_appended: assert property ($past(tx_st_q == TX_PAY) && tx_st_q != TX_PAY && crc_en
		|-> tx_st_q == TX_CRC)
		else $error("crc bytes not appended after payload");
	c_tx_crc: cover property (tx_st_q == TX_CRC ##1 tx_st_q == TX_IDLE);
	c_tx_stall: cover property (stall);

	////////////////////////////////////////////////////////////////////////
	// Receive deframer and preamble sense
	rx_state_type rx_st_q;
	logic prev_q;
	logic [3:0] run_q;
	logic [31:0] ssh_q;
	logic [15:0] rcrc_q;
	logic [2:0] rbit_q;
	logic [6:0] rsh_q;
	logic [8:0] rbytes_q;
	logic [7:0] rlen_q;
	logic pd_q;
	logic sf_q;
	logic [7:0] rbyte_q;
	logic rbv_q;
	logic pv_q;
	logic pe_q;
	logic rx_on_q;
	logic [15:0] sniff_q;
	logic strobe;
	logic qualify;
	logic [31:0] snext;
	logic [31:0] sexp;
	logic [15:0] rcrc_n;
	logic [8:0] rtotal;

	assign strobe = rx_bit_strobe_in & rx_on_q;
	assign qualify = manch ? rx_bit_in : (rx_bit_in != prev_q);
	assign snext = {ssh_q[30:0], rx_bit_in};
	assign sexp = sync_q >> {3'h4 - sync_len_q, 3'h0};
	assign rcrc_n = crc_step(rcrc_q, rx_bit_in, itu);
	assign rtotal = {1'b0, rlen_q} + (crc_en ? 9'h002 : 9'h000);

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rx_st_q <= RX_HUNT;
			prev_q <= 1'b0;
			run_q <= 4'h0;
			ssh_q <= 32'h00000000;
			rcrc_q <= CRC_SEED;
			rbit_q <= 3'h0;
			rsh_q <= 7'h00;
			rbytes_q <= 9'h000;
			rlen_q <= 8'h00;
			pd_q <= 1'b0;
			sf_q <= 1'b0;
			rbyte_q <= 8'h00;
			rbv_q <= 1'b0;
			pv_q <= 1'b0;
			pe_q <= 1'b0;
		end
		else
		begin
			sf_q <= 1'b0;
			rbv_q <= 1'b0;
			pv_q <= 1'b0;
			pe_q <= 1'b0;
			if (!rx_enable_in)
			begin
				rx_st_q <= RX_HUNT;
				run_q <= 4'h0;
				pd_q <= 1'b0;
			end
			else if (strobe)
			begin
				unique case (rx_st_q)
					RX_HUNT:
					begin
						prev_q <= rx_bit_in;
						if (!qualify)
							run_q <= 4'h0;
						else if (run_q == DETECT_RUN)
						begin
							rx_st_q <= RX_SYNC;
							pd_q <= 1'b1;
							run_q <= 4'h0;
							ssh_q <= 32'h00000000;
						end
						else
							run_q <= run_q + 4'h1;
					end
					RX_SYNC:
					begin
						ssh_q <= snext;
						if (((snext ^ sexp) & len_mask(sync_len_q)) == 32'h00000000)
						begin
							rx_st_q <= RX_DATA;
							sf_q <= 1'b1;
							rcrc_q <= CRC_SEED;
							rbit_q <= 3'h0;
							rbytes_q <= 9'h000;
							rlen_q <= rx_len_in;
						end
					end
					RX_DATA:
					begin
						rsh_q <= {rsh_q[5:0], rx_bit_in};
						rcrc_q <= rcrc_n;
						rbit_q <= rbit_q + 3'h1;
						if (rbit_q == 3'h7)
						begin
							rbytes_q <= rbytes_q + 9'h001;
							if (rbytes_q < {1'b0, rlen_q})
							begin
								rbyte_q <= {rsh_q, rx_bit_in};
								rbv_q <= 1'b1;
							end
							if (rbytes_q + 9'h001 == rtotal)
							begin
								rx_st_q <= RX_HUNT;
								pd_q <= 1'b0;
								if (!crc_en || rcrc_n == 16'h0000)
									pv_q <= 1'b1;
								else
									pe_q <= 1'b1;
							end
						end
					end
				endcase
			end
		end
	end

	// Listens long enough for two detection runs, then sleeps
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rx_on_q <= 1'b0;
			sniff_q <= 16'h0000;
		end
		else if (!rx_enable_in)
		begin
			rx_on_q <= 1'b0;
			sniff_q <= 16'h0000;
		end
		else if (!preamble_sense_rx_mode || rx_st_q != RX_HUNT)
		begin
			rx_on_q <= 1'b1;
			sniff_q <= 16'h0000;
		end
		else if (rx_on_q)
		begin
			sniff_q <= (sniff_q == SNIFF_ON_CYC - 16'h0001) ? 16'h0000 : sniff_q + 16'h0001;
			if (sniff_q == SNIFF_ON_CYC - 16'h0001)
				rx_on_q <= 1'b0;
		end
		else
		begin
			sniff_q <= (sniff_q == SNIFF_OFF_LAST) ? 16'h0000 : sniff_q + 16'h0001;
			if (sniff_q == SNIFF_OFF_LAST)
				rx_on_q <= 1'b1;
		end
	end

	a_detect_run: assert property ($rose(pd_q) |-> $past(run_q) == DETECT_RUN)
		else $error("preamble detected after wrong bit count");
	a_sniff_bound: assert property (rx_on_q && preamble_sense_rx_mode && rx_st_q == RX_HUNT |-> sniff_q < SNIFF_ON_CYC)
		else $error("sniff listen window overran");
	a_crc_seed: assert property ($rose(rx_st_q == RX_DATA) |-> rcrc_q == CRC_SEED)
		else $error("receive crc not preset");
	a_valid_xor_err: assert property (!(pv_q && pe_q))
		else $error("valid and error raised together");
	c_rx_valid: cover property (sf_q ##[1:1000] pv_q);
	c_rx_error: cover property (pe_q);

	////////////////////////////////////////////////////////////////////////
	assign device_to_host_line_out = dout_q;
	assign tx_chip_out = tx_chip_q;
	assign tx_active_out = tx_active_q;
	assign rx_on_out = rx_on_q;
	assign preamble_detected_out = pd_q;
	assign sync_found_out = sf_q;
	assign rx_byte_out = rbyte_q;
	assign rx_byte_valid_out = rbv_q;
	assign packet_valid_out = pv_q;
	assign packet_error_out = pe_q;
	assign config_applied_out = cfg_loaded_q;
	assign config_ok_out = cfg_ok_q;
endmodule

/* testbench/spi_host.sv */
// Host model: sends serial transactions to the packet handler.
// Assumes the system clock paces every pin change.
`timescale 1ns/1ps

module spi_host (
	input wire logic clk_in,
	input wire logic device_to_host_line_in,
	output logic host_select_n_out,
	output logic spi_clk_out,
	output logic host_to_device_line_out
);
	initial
	begin
		host_select_n_out = 1'b1;
		spi_clk_out = 1'b0;
		host_to_device_line_out = 1'b0;
	end

	////////////////////
	// Command byte first, then its parameters, under one select
	task automatic xfer(input logic [7:0] d [$], output logic [7:0] r);
		logic [7:0] b;
		@(posedge clk_in) host_select_n_out <= 1'b0;
		foreach (d[k])
		begin
			b = d[k];
			for (int i = 7; i >= 0; i--)
			begin
				// 200 ns serial clock: 4 clk low, 4 clk high
				repeat (2) @(posedge clk_in);
				host_to_device_line_out <= b[i];
				repeat (2) @(posedge clk_in);
				spi_clk_out <= 1'b1;
				r[i] = device_to_host_line_in;
				repeat (4) @(posedge clk_in);
				spi_clk_out <= 1'b0;
			end
		end
		repeat (4) @(posedge clk_in);
		host_select_n_out <= 1'b1;
		// Idle line must not look like the last bit sent
		host_to_device_line_out <= ~host_to_device_line_out;
		repeat (6) @(posedge clk_in);
	endtask
endmodule

/* testbench/tb.sv */
// Testbench: serial configuration, transmit framing, receive CRC check.
// Assumes the host model on the serial pins; receive bits are fed directly.
`timescale 1ns/1ps

module tb;
	import pkt_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic host_select_n, spi_clk, host_to_device_line, device_to_host_line;
	logic tx_start = 1'b0;
	logic [7:0] tx_len = 8'h02;
	logic rx_enable = 1'b0;
	logic rx_bit = 1'b0;
	logic rx_bit_strobe = 1'b0;
	logic [7:0] rx_len = 8'h02;
	logic tx_chip, tx_active, rx_on, preamble_detected, sync_found, rx_byte_valid;
	logic packet_valid, packet_error, config_applied, config_ok;
	logic [7:0] rx_byte, last_rb, r;
	logic [15:0] c;
	int n_tests = 0, n_mismatch = 0, n_pv = 0, n_pe = 0, n_sf = 0;

	always #12.5 clk = ~clk;

	radio_packet_handler #(.SNIFF_OFF_CYC(50)) dut (.clk_sys_in(clk), .rst_in(rst),
		.host_select_n_in(host_select_n), .spi_clk_in(spi_clk),
		.host_to_device_line_in(host_to_device_line), .device_to_host_line_out(device_to_host_line),
		.tx_start_in(tx_start), .tx_len_in(tx_len), .tx_chip_out(tx_chip), .tx_active_out(tx_active),
		.rx_enable_in(rx_enable), .rx_bit_in(rx_bit), .rx_bit_strobe_in(rx_bit_strobe),
		.rx_len_in(rx_len), .rx_on_out(rx_on), .preamble_detected_out(preamble_detected),
		.sync_found_out(sync_found), .rx_byte_out(rx_byte), .rx_byte_valid_out(rx_byte_valid),
		.packet_valid_out(packet_valid), .packet_error_out(packet_error),
		.config_applied_out(config_applied), .config_ok_out(config_ok));

	spi_host host (.clk_in(clk), .device_to_host_line_in(device_to_host_line),
		.host_select_n_out(host_select_n), .spi_clk_out(spi_clk),
		.host_to_device_line_out(host_to_device_line));

	always @(posedge clk)
	begin
		n_pv <= n_pv + int'(packet_valid === 1'b1);
		n_pe <= n_pe + int'(packet_error === 1'b1);
		n_sf <= n_sf + int'(sync_found === 1'b1);
		if (rx_byte_valid === 1'b1)
			last_rb <= rx_byte;
	end

	////////////////////
	function automatic logic [15:0] crc_b(input logic [15:0] v, input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			v = (v[15] ^ b[i]) ? ({v[14:0], 1'b0} ^ 16'h8005) : {v[14:0], 1'b0};
		return v;
	endfunction

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic cts_wait();
		r = 8'h00;
		for (int i = 0; i < 20 && r !== 8'hff; i++)
			host.xfer('{CMD_CTS, 8'h00}, r);
		chk("cts", 16'h00ff, {8'h00, r});
		r = 8'h00;
	endtask

	task automatic rx_send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
		begin
			@(posedge clk) rx_bit <= b[i];
			rx_bit_strobe <= 1'b1;
			@(posedge clk) rx_bit_strobe <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask

	////////////////////
	task automatic t_reset();
		chk("idle", 16'h0000, {12'h000, tx_active, tx_chip, config_applied, config_ok});
		@(posedge clk) tx_start <= 1'b1;
		@(posedge clk) tx_start <= 1'b0;
		repeat (10) @(posedge clk);
		chk("unconfigured start", 16'h0000, {15'h0000, tx_active});
	endtask

	task automatic t_rx(input logic [7:0] flip);
		int pv, pe, sf;
		pv = n_pv;
		pe = n_pe;
		sf = n_sf;
		c = crc_b(crc_b(16'hffff, 8'h3c), 8'hc3);
		@(posedge clk) rx_enable <= 1'b1;
		repeat (4) rx_send(8'h55);
		chk("preamble", 16'h0003, {14'h0000, rx_on, preamble_detected});
		rx_send(8'h2d);
		rx_send(8'hd4);
		rx_send(8'h3c);
		rx_send(8'hc3);
		rx_send(c[15:8]);
		rx_send(c[7:0] ^ flip);
		repeat (4) @(posedge clk);
		chk("sync", 16'(sf + 1), 16'(n_sf));
		chk("byte", 16'h00c3, {8'h00, last_rb});
		chk("valid", 16'(pv + int'(flip == 0)), 16'(n_pv));
		chk("error", 16'(pe + int'(flip != 0)), 16'(n_pe));
		chk("preamble end", 16'h0000, {15'h0000, preamble_detected});
		@(posedge clk) rx_enable <= 1'b0;
	endtask

	task automatic t_config();
		host.xfer('{8'h66, 8'h05, 8'h01, 8'h01}, r);
		host.xfer('{CMD_NOP}, r);
		cts_wait();
		host.xfer('{8'h66, 8'ha5, 8'h00, 8'h00, 8'h00}, r);
		host.xfer('{CMD_APPLY}, r);
		host.xfer('{CMD_VERIFY}, r);
		cts_wait();
		chk("config", 16'h0003, {14'h0000, config_applied, config_ok});
	endtask

	task automatic t_tx();
		logic [7:0] a, b;
		logic [7:0] e [6];
		c = crc_b(crc_b(16'hffff, 8'h3c), 8'hc3);
		e = '{8'hff, 8'ha5, 8'h3c, 8'hc3, c[15:8], c[7:0]};
		host.xfer('{8'h66, 8'h3c, 8'hc3}, r);
		@(posedge clk) tx_start <= 1'b1;
		@(posedge clk) tx_start <= 1'b0;
		while (tx_active !== 1'b1)
			@(posedge clk);
		// Sample each chip in its middle, clear of edge jitter
		repeat (100) @(posedge clk);
		for (int k = 0; k < 6; k++)
		begin
			for (int i = 7; i >= 0; i--)
			begin
				a[i] = tx_chip;
				repeat (200) @(posedge clk);
				b[i] = tx_chip;
				repeat (200) @(posedge clk);
			end
			chk("chip first", {8'h00, e[k]}, {8'h00, a});
			chk("chip second", {8'h00, ~e[k]}, {8'h00, b});
		end
		chk("tx end", 16'h0000, {14'h0000, tx_active, tx_chip});
	endtask

	////////////////////
	initial
	begin
		repeat (80000) @(posedge clk);
		n_mismatch++;
		finish_test();
	end

	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_reset();
		t_rx(8'h00);
		t_rx(8'h01);
		t_config();
		t_tx();
		finish_test();
	end
endmodule
